// ===== test_timer0_waveform_control.sv
// self-checking bench for the timer block over its register bus
`timescale 1ns/10ps
`default_nettype none
`include "timer0_defines.vh"
module test_timer0_waveform_control;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_val;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rd_resp;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, external_count_pin, ack_match_a, ack_overflow, ack_match_b;
    logic        wave_out_a, wave_out_a_oe_n, wave_out_b, wave_out_b_oe_n, w0;
    logic        match_flag_a, overflow_flag, match_flag_b;
    int          n_mismatch = 0, checks_done = 0, i;
    logic [5:0]  idx_list [7] = '{6'h30, 6'h33, 6'h34, 6'h35, 6'h36, 6'h37, 6'h38};

    timer0_waveform_control dut_u (.*);

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // ----------------------------------------
    // bus and compare tasks
    // ----------------------------------------
    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er = 2'h0);
        @(posedge aclk);
        s_axi_awaddr <= {idx, 2'h0};
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("bresp", s_axi_bresp, er);
    endtask
    task automatic rd(input logic [5:0] idx);
        @(posedge aclk);
        s_axi_araddr <= {idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd_val = s_axi_rdata;
        rd_resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic rc(input logic [5:0] idx, input logic [31:0] exp, input string name);
        rd(idx);
        chk(name, rd_val, exp);
    endtask
    task automatic wait_flag(input logic ovf);
        do @(posedge aclk); while ((ovf ? overflow_flag : match_flag_b) !== 1'b1);
    endtask
    // compare set up in mode 0 so the level takes effect before the pwm mode starts
    task automatic pwm_case(input logic [2:0] m, input logic [1:0] a, input logic e1);
        wr(`IDX_CONTROL_B, 8'h00);
        wr(`IDX_CONTROL_A, 8'h00);
        wr(`IDX_COMPARE_A, 8'hff);
        wr(`IDX_COMPARE_B, 8'h80);
        wr(`IDX_COUNT_VALUE, 8'h00);
        wr(`IDX_EVENT_FLAGS, 8'h07);
        wr(`IDX_CONTROL_A, {2'h0, a, 2'h0, m[1:0]});
        wr(`IDX_CONTROL_B, {4'h0, m[2], `CS_DIV1});
        wait_flag(1'b0);
        chk("wave_b at match", wave_out_b, e1);
        wr(`IDX_EVENT_FLAGS, 8'h02);
        wait_flag(1'b1);
        chk("wave_b at overflow", wave_out_b, !e1);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge aclk);
        n_mismatch++;
        report_and_stop;
    end

    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
        {external_count_pin, ack_match_a, ack_overflow, ack_match_b} = 4'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0000_0000_0000;
        s_axi_wstrb = 4'h1;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (idx_list[k]) rc(idx_list[k], 32'h0000_0000, "reset value");
        rd(6'h00);
        chk("unmapped rresp", rd_resp, `RESP_SLVERR);
        wr(6'h3f, 8'h12, `RESP_SLVERR);
        wr(`IDX_CONTROL_A, 8'hff);
        rc(`IDX_CONTROL_A, 32'h0000_00f3, "control_a");
        wr(`IDX_CONTROL_B, 8'hf0);
        rc(`IDX_CONTROL_B, 32'h0000_0000, "control_b");
        chk("wave_b forced in pwm", wave_out_b, 1'b0);
        wr(`IDX_COUNT_VALUE, 8'h5a);
        rc(`IDX_COUNT_VALUE, 32'h0000_005a, "count");
        wr(`IDX_PIN_DIRECTION, 8'h02);
        for (i = 0; i < 5; i++) begin
            wr(`IDX_CONTROL_A, {{2{2'(10'h379 >> 2 * i)}}, 2'h0, i == 4 ? 2'h2 : 2'h0});
            wr(`IDX_CONTROL_B, 8'hc0);
            chk("forced wave_a", wave_out_a, (5'h15 >> i) & 5'h01);
            chk("forced wave_b", wave_out_b, (5'h15 >> i) & 5'h01);
            chk("oe_n b", wave_out_b_oe_n, 1'b0);
            rc(`IDX_EVENT_FLAGS, 32'h0000_0000, "flags after force");
        end
        rc(`IDX_COUNT_VALUE, 32'h0000_005a, "count after ctc force");
        wr(`IDX_CONTROL_A, 8'h10);
        wr(`IDX_COMPARE_B, 8'h05);
        wr(`IDX_COUNT_VALUE, 8'h05);
        w0 = wave_out_b;
        wr(`IDX_CONTROL_B, {5'h00, `CS_DIV1});
        repeat (3) @(posedge aclk);
        chk("match_b after count write", match_flag_b, 1'b0);
        wait_flag(1'b0);
        chk("wave_b toggled", wave_out_b, !w0);
        chk("overflow at max", overflow_flag, 1'b1);
        wr(`IDX_CONTROL_B, 8'h00);
        ack_match_b <= 1'b1;
        @(posedge aclk);
        ack_match_b <= 1'b0;
        @(posedge aclk);
        chk("match_b after ack", match_flag_b, 1'b0);
        wr(`IDX_EVENT_FLAGS, 8'h02);
        chk("overflow after write one", overflow_flag, 1'b0);
        wr(`IDX_CONTROL_A, 8'h00);
        @(posedge aclk);
        chk("oe_n b off", wave_out_b_oe_n, 1'b1);
        pwm_case(3'h3, 2'h2, 1'b0);
        pwm_case(3'h3, 2'h3, 1'b1);
        pwm_case(3'h7, 2'h2, 1'b0);
        pwm_case(3'h1, 2'h2, 1'b0);
        pwm_case(3'h1, 2'h3, 1'b1);
        pwm_case(3'h5, 2'h3, 1'b1);
        wr(`IDX_EVENT_FLAGS, 8'h04);
        wr(`IDX_COMPARE_B, 8'h10);
        repeat (40) @(posedge aclk);
        chk("match_b before top", match_flag_b, 1'b0);
        for (i = 0; i < 2; i++) begin
            wr(`IDX_CONTROL_B, 8'h00);
            wr(`IDX_COUNT_VALUE, 8'h00);
            wr(`IDX_CONTROL_B, {5'h00, i ? `CS_EXT_FALL : `CS_EXT_RISE});
            repeat (3) begin
                repeat (4) @(posedge aclk);
                external_count_pin <= 1'b1;
                repeat (4) @(posedge aclk);
                external_count_pin <= 1'b0;
            end
            repeat (6) @(posedge aclk);
            wr(`IDX_CONTROL_B, 8'h00);
            rc(`IDX_COUNT_VALUE, 32'h0000_0003, "pin edge count");
        end
        report_and_stop;
    end
endmodule // test_timer0_waveform_control
`default_nettype wire

// ===== timer0_defines.vh
// register indices, field positions and codes of the 8-bit timer block
`ifndef TIMER0_DEFINES_VH
`define TIMER0_DEFINES_VH

// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define IDX_CONTROL_A     6'h30
`define IDX_CONTROL_B     6'h33
`define IDX_COUNT_VALUE   6'h34
`define IDX_COMPARE_A     6'h35
`define IDX_COMPARE_B     6'h36
`define IDX_EVENT_FLAGS   6'h37
`define IDX_PIN_DIRECTION 6'h38

// ----------------------------------------
// field positions
// ----------------------------------------
`define CA_ACT_A_HI   7
`define CA_ACT_A_LO   6
`define CA_ACT_B_HI   5
`define CA_ACT_B_LO   4
`define CA_WGM_HI     1
`define CA_WGM_LO     0
`define CB_FORCE_A    7
`define CB_FORCE_B    6
`define CB_WGM2       3
`define CB_CS_HI      2
`define CB_CS_LO      0
`define FL_MATCH_B    2
`define FL_OVERFLOW   1
`define FL_MATCH_A    0
`define DIR_A         0
`define DIR_B         1

// ----------------------------------------
// modes, clock sources, actions
// ----------------------------------------
`define MODE_NORMAL   3'h0
`define MODE_PC_FF    3'h1
`define MODE_CTC      3'h2
`define MODE_FAST_FF  3'h3
`define MODE_PC_OCR   3'h5
`define MODE_FAST_OCR 3'h7
`define CS_STOP       3'h0
`define CS_DIV1       3'h1
`define CS_DIV8       3'h2
`define CS_DIV64      3'h3
`define CS_DIV256     3'h4
`define CS_DIV1024    3'h5
`define CS_EXT_FALL   3'h6
`define CS_EXT_RISE   3'h7
`define ACT_OFF       2'h0
`define ACT_TOGGLE    2'h1
`define ACT_CLEAR     2'h2
`define ACT_SET       2'h3
`define KIND_PLAIN    2'h0
`define KIND_FAST     2'h1
`define KIND_PC       2'h2

// ----------------------------------------
// values
// ----------------------------------------
`define COUNT_MAX     8'hff
`define COUNT_BOTTOM  8'h00
`define BYTE_ZERO     8'h00
`define WORD_ZERO     32'h0000_0000
`define PRESC_ZERO    10'h000
`define PRESC_ONE     10'h001
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

// ===== timer0_waveform_control.v
// 8-bit timer/counter with two compare channels behind an AXI4-Lite slave
//
// Summary of operation
// - nonzero output b action takes over pin when its pin direction bit is set
// - non-pwm actions: off, toggle, clear, set
// - fast pwm: clear/set on match, reverse at top
// - compare at top: ignore match, act at top
// - phase correct: opposite actions up and down
// - reserved control bits read as zero
// - waveform select picks mode and top
// - compare writes immediate, buffered in pwm modes
// - overflow flag at max, bottom or top
// - normal, clear-on-match, fast and phase pwm
// - force strobe applies action in non-pwm only
// - forced compare sets no flag, no clear
// - force strobe bits read as zero
// - clock select: stop, prescaler taps, external edges
// - external pin counts even when driven
// - counter readable, writable; write blocks next match
// - compare levels compared with counter continuously
// - match flags set by hardware, cleared by ack/one
`timescale 1ns/10ps
`default_nettype none
`include "timer0_defines.vh"

module timer0_waveform_control (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        external_count_pin,
    input  wire        ack_match_a,
    input  wire        ack_overflow,
    input  wire        ack_match_b,
    output reg         wave_out_a,
    output reg         wave_out_a_oe_n,
    output reg         wave_out_b,
    output reg         wave_out_b_oe_n,
    output reg         match_flag_a,
    output reg         overflow_flag,
    output reg         match_flag_b
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    reg [1:0]  output_a_action;
    reg [1:0]  output_b_action;
    reg [1:0]  waveform_lo;
    reg        waveform_hi;
    reg [2:0]  clock_source_select;
    reg [7:0]  timer_count_value;
    reg [7:0]  compare_buf_a;
    reg [7:0]  compare_level_a;
    reg [7:0]  compare_buf_b;
    reg [7:0]  compare_level_b;
    reg [1:0]  pin_direction;
    reg        count_up;
    reg        block_match;
    reg [9:0]  prescale;
    reg        ext_s1;
    reg        ext_s2;
    reg        ext_s3;
    reg        aw_got;
    reg        w_got;
    reg [7:0]  aw_addr;
    reg [31:0] w_data;
    reg [3:0]  w_strb;

    // ----------------------------------------
    // functions
    // ----------------------------------------
    function tick_of;
        input [2:0] cs;
        input [9:0] pre;
        input       rise;
        input       fall;
        begin
            case (cs)
                `CS_DIV1:     tick_of = 1'b1;
                `CS_DIV8:     tick_of = &pre[2:0];
                `CS_DIV64:    tick_of = &pre[5:0];
                `CS_DIV256:   tick_of = &pre[7:0];
                `CS_DIV1024:  tick_of = &pre[9:0];
                `CS_EXT_FALL: tick_of = fall;
                `CS_EXT_RISE: tick_of = rise;
                default:      tick_of = 1'b0;
            endcase
        end
    endfunction

    function wave_step;
        input       cur;
        input [1:0] act;
        input       hit;
        input       at_t;
        input       up;
        input [1:0] kind;
        input       eqtop;
        input       tog;
        begin
            wave_step = cur;
            case (kind)
                `KIND_PLAIN: begin
                    if (hit && act == `ACT_TOGGLE)
                        wave_step = ~cur;
                    else if (hit && act[1])
                        wave_step = act[0];
                end
                `KIND_FAST: begin
                    if (hit && tog && act == `ACT_TOGGLE)
                        wave_step = ~cur;
                    else if (act[1] && at_t)
                        wave_step = ~act[0];
                    else if (act[1] && hit && !eqtop)
                        wave_step = act[0];
                end
                `KIND_PC: begin
                    if (hit && tog && act == `ACT_TOGGLE)
                        wave_step = ~cur;
                    else if (act[1] && hit && !eqtop)
                        wave_step = up ? act[0] : ~act[0];
                    else if (act[1] && at_t && eqtop)
                        wave_step = ~act[0];
                end
                default: wave_step = cur;
            endcase
        end
    endfunction

    // ----------------------------------------
    // mode decode
    // ----------------------------------------
    wire [2:0] mode      = {waveform_hi, waveform_lo};
    wire       is_pc     = (mode == `MODE_PC_FF) || (mode == `MODE_PC_OCR);
    wire       is_fast   = (mode == `MODE_FAST_FF) || (mode == `MODE_FAST_OCR);
    wire       is_pwm    = is_pc || is_fast;
    wire       top_is_a  = (mode == `MODE_CTC) || (mode == `MODE_PC_OCR) ||
                           (mode == `MODE_FAST_OCR);
    wire [7:0] top_value = top_is_a ? compare_level_a : `COUNT_MAX;
    wire [1:0] kind      = is_fast ? `KIND_FAST : (is_pc ? `KIND_PC : `KIND_PLAIN);
    wire       at_top    = (timer_count_value == top_value);

    // the pin is read only after two stages, so counting works even when
    // the same pin is being driven by software
    wire tick = tick_of(clock_source_select, prescale,
                        ext_s2 & ~ext_s3, ~ext_s2 & ext_s3);

    wire match_a = tick && !block_match && (timer_count_value == compare_level_a);
    wire match_b = tick && !block_match && (timer_count_value == compare_level_b);
    wire top_ev  = tick && at_top;
    wire ovf_ev  = (mode == `MODE_FAST_OCR) ? top_ev :
                   (is_pc ? (tick && timer_count_value == `COUNT_BOTTOM) :
                            (tick && timer_count_value == `COUNT_MAX));

    // ----------------------------------------
    // register write decode
    // ----------------------------------------
    wire       wr_go  = aw_got && w_got && !s_axi_bvalid;
    wire       wr_en  = wr_go && w_strb[0];
    wire [5:0] wr_idx = aw_addr[7:2];
    wire [7:0] wr_dat = w_data[7:0];
    wire       wr_ok  = (wr_idx == `IDX_CONTROL_A) || (wr_idx == `IDX_CONTROL_B) ||
                        (wr_idx == `IDX_COUNT_VALUE) || (wr_idx == `IDX_COMPARE_A) ||
                        (wr_idx == `IDX_COMPARE_B) || (wr_idx == `IDX_EVENT_FLAGS) ||
                        (wr_idx == `IDX_PIN_DIRECTION);
    wire wr_ctl_b  = wr_en && wr_idx == `IDX_CONTROL_B;
    wire wr_count  = wr_en && wr_idx == `IDX_COUNT_VALUE;
    wire wr_cmp_a  = wr_en && wr_idx == `IDX_COMPARE_A;
    wire wr_cmp_b  = wr_en && wr_idx == `IDX_COMPARE_B;
    wire wr_flags  = wr_en && wr_idx == `IDX_EVENT_FLAGS;

    // strobes only act outside pwm; they never reach the flags or the counter
    wire force_a = wr_ctl_b && wr_dat[`CB_FORCE_A] && !is_pwm;
    wire force_b = wr_ctl_b && wr_dat[`CB_FORCE_B] && !is_pwm;

    // ----------------------------------------
    // read decode
    // ----------------------------------------
    reg [7:0] rd_byte;
    reg       rd_ok;
    wire [5:0] rd_idx = s_axi_araddr[7:2];
    always @* begin
        rd_ok   = 1'b1;
        rd_byte = `BYTE_ZERO;
        if (rd_idx == `IDX_CONTROL_A) begin
            rd_byte = {output_a_action, output_b_action, 2'h0, waveform_lo};
        end else if (rd_idx == `IDX_CONTROL_B) begin
            rd_byte = {4'h0, waveform_hi, clock_source_select};
        end else if (rd_idx == `IDX_COUNT_VALUE) begin
            rd_byte = timer_count_value;
        end else if (rd_idx == `IDX_COMPARE_A) begin
            rd_byte = compare_buf_a;
        end else if (rd_idx == `IDX_COMPARE_B) begin
            rd_byte = compare_buf_b;
        end else if (rd_idx == `IDX_EVENT_FLAGS) begin
            rd_byte = {5'h00, match_flag_b, overflow_flag, match_flag_a};
        end else if (rd_idx == `IDX_PIN_DIRECTION) begin
            rd_byte = {6'h00, pin_direction};
        end else begin
            rd_ok = 1'b0;
        end
    end

    // ----------------------------------------
    // axi4-lite slave
    // ----------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= `RESP_OKAY;
            s_axi_rdata   <= `WORD_ZERO;
            aw_got        <= 1'b0;
            w_got         <= 1'b0;
            aw_addr       <= `BYTE_ZERO;
            w_data        <= `WORD_ZERO;
            w_strb        <= 4'h0;
        end else begin
            if (!aw_got && !s_axi_awready)
                s_axi_awready <= 1'b1;
            if (!w_got && !s_axi_wready)
                s_axi_wready <= 1'b1;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got        <= 1'b1;
                aw_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got        <= 1'b1;
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_got       <= 1'b0;
                w_got        <= 1'b0;
            end
            if (!s_axi_rvalid && !s_axi_arready)
                s_axi_arready <= 1'b1;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= {24'h00_0000, rd_byte};
                s_axi_rresp   <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // control registers and compare buffers
    // ----------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            output_a_action     <= `ACT_OFF;
            output_b_action     <= `ACT_OFF;
            waveform_lo         <= 2'h0;
            waveform_hi         <= 1'b0;
            clock_source_select <= `CS_STOP;
            compare_buf_a       <= `BYTE_ZERO;
            compare_level_a     <= `BYTE_ZERO;
            compare_buf_b       <= `BYTE_ZERO;
            compare_level_b     <= `BYTE_ZERO;
            pin_direction       <= 2'h0;
        end else begin
            if (wr_en && wr_idx == `IDX_CONTROL_A) begin
                output_a_action <= wr_dat[`CA_ACT_A_HI:`CA_ACT_A_LO];
                output_b_action <= wr_dat[`CA_ACT_B_HI:`CA_ACT_B_LO];
                waveform_lo     <= wr_dat[`CA_WGM_HI:`CA_WGM_LO];
            end
            if (wr_ctl_b) begin
                waveform_hi         <= wr_dat[`CB_WGM2];
                clock_source_select <= wr_dat[`CB_CS_HI:`CB_CS_LO];
            end
            if (wr_en && wr_idx == `IDX_PIN_DIRECTION)
                pin_direction <= wr_dat[1:0];
            if (wr_cmp_a)
                compare_buf_a <= wr_dat;
            if (wr_cmp_b)
                compare_buf_b <= wr_dat;
            // pwm modes pick up the buffer at top so a period is never torn
            if (!is_pwm) begin
                compare_level_a <= wr_cmp_a ? wr_dat : compare_buf_a;
                compare_level_b <= wr_cmp_b ? wr_dat : compare_buf_b;
            end else if (top_ev) begin
                compare_level_a <= compare_buf_a;
                compare_level_b <= compare_buf_b;
            end
        end
    end

    // ----------------------------------------
    // prescaler, pin synchroniser, counter
    // ----------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            prescale          <= `PRESC_ZERO;
            ext_s1            <= 1'b0;
            ext_s2            <= 1'b0;
            ext_s3            <= 1'b0;
            timer_count_value <= `COUNT_BOTTOM;
            count_up          <= 1'b1;
            block_match       <= 1'b0;
        end else begin
            prescale <= prescale + `PRESC_ONE;
            ext_s1   <= external_count_pin;
            ext_s2   <= ext_s1;
            ext_s3   <= ext_s2;
            if (tick)
                block_match <= 1'b0;
            if (wr_count) begin
                timer_count_value <= wr_dat;
                block_match       <= 1'b1;
            end else if (tick) begin
                if (is_pc) begin
                    if (count_up && at_top) begin
                        count_up          <= 1'b0;
                        timer_count_value <= timer_count_value - 8'h01;
                    end else if (!count_up && timer_count_value == `COUNT_BOTTOM) begin
                        count_up          <= 1'b1;
                        timer_count_value <= timer_count_value + 8'h01;
                    end else if (count_up) begin
                        timer_count_value <= timer_count_value + 8'h01;
                    end else begin
                        timer_count_value <= timer_count_value - 8'h01;
                    end
                end else begin
                    count_up <= 1'b1;
                    if ((is_fast || mode == `MODE_CTC) && at_top)
                        timer_count_value <= `COUNT_BOTTOM;
                    else
                        timer_count_value <= timer_count_value + 8'h01;
                end
            end
        end
    end

    // ----------------------------------------
    // flags, set wins over clear
    // ----------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            match_flag_a  <= 1'b0;
            overflow_flag <= 1'b0;
            match_flag_b  <= 1'b0;
        end else begin
            if (match_a)
                match_flag_a <= 1'b1;
            else if (ack_match_a || (wr_flags && wr_dat[`FL_MATCH_A]))
                match_flag_a <= 1'b0;
            if (ovf_ev)
                overflow_flag <= 1'b1;
            else if (ack_overflow || (wr_flags && wr_dat[`FL_OVERFLOW]))
                overflow_flag <= 1'b0;
            if (match_b)
                match_flag_b <= 1'b1;
            else if (ack_match_b || (wr_flags && wr_dat[`FL_MATCH_B]))
                match_flag_b <= 1'b0;
        end
    end

    // ----------------------------------------
    // waveform outputs and pin enables
    // ----------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            wave_out_a      <= 1'b0;
            wave_out_b      <= 1'b0;
            wave_out_a_oe_n <= 1'b1;
            wave_out_b_oe_n <= 1'b1;
        end else begin
            wave_out_a <= wave_step(wave_out_a, output_a_action, match_a || force_a,
                                    top_ev, count_up, kind,
                                    compare_level_a == top_value, waveform_hi);
            // channel b has no toggle in pwm modes, that code is reserved
            wave_out_b <= wave_step(wave_out_b, output_b_action, match_b || force_b,
                                    top_ev, count_up, kind,
                                    compare_level_b == top_value, 1'b0);
            wave_out_a_oe_n <= !(pin_direction[`DIR_A] && output_a_action != `ACT_OFF);
            wave_out_b_oe_n <= !(pin_direction[`DIR_B] &&
                                 output_b_action != `ACT_OFF);
        end
    end

endmodule // timer0_waveform_control
`default_nettype wire

// ===== timer0_waveform_control_chk.sv
// bus timing and flag checks for the timer block
`timescale 1ns/10ps
`default_nettype none
`include "timer0_defines.vh"
module timer0_waveform_control_chk (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        ack_match_b,
    input wire logic        match_flag_b,
    input wire logic        wave_out_b_oe_n
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic rd_mapped;
    assign rd_mapped = s_axi_araddr[7:2] inside {[6'h30:6'h30], [6'h33:6'h38]};
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    AST_B_AFTER_PAIR: assert property (wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid && !s_axi_awready)
        else $error("write response late");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    // readies come back only one edge after the response is gone
    AST_READY_BACK: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##1 (s_axi_awready && s_axi_wready))
        else $error("write readies not restored");
    AST_R_AFTER_AR: assert property (ar_taken |=> s_axi_rvalid && !s_axi_arready && s_axi_rdata[31:8] == 24'h00_0000)
        else $error("read answer wrong");
    AST_CTRL_B_RESERVED: assert property (ar_taken ##0 s_axi_araddr[7:2] == `IDX_CONTROL_B |=> s_axi_rdata[7:4] == 4'h0)
        else $error("control b upper bits not zero");
    AST_CTRL_A_RESERVED: assert property (ar_taken ##0 s_axi_araddr[7:2] == `IDX_CONTROL_A |=> s_axi_rdata[3:2] == 2'h0)
        else $error("control a reserved bits not zero");
    AST_UNMAPPED_READ: assert property (ar_taken ##0 !rd_mapped |=> s_axi_rresp == `RESP_SLVERR)
        else $error("unmapped read not refused");
    AST_FLAG_B_FALL: assert property ($fell(match_flag_b) |-> $past(ack_match_b) || $rose(s_axi_bvalid))
        else $error("match flag b cleared without cause");
    // the enable follows the register one edge after the response goes up
    AST_OE_B_WRITE: assert property ($changed(wave_out_b_oe_n) |->
        $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2))
        else $error("output b enable changed without register write");
endmodule // timer0_waveform_control_chk
bind timer0_waveform_control timer0_waveform_control_chk chk_u (.*);
`default_nettype wire
